// >>> logic/prog_consts.svh
`ifndef PROG_CONSTS_SVH
`define PROG_CONSTS_SVH

// ----------------------------------------
// Clock and time conversion
// ----------------------------------------
`define CLK_MHZ          25
// Least time in ns to whole cycles, rounded up
`define NS2CYC(ns)       ((((ns) * `CLK_MHZ) + 999) / 1000)

// ----------------------------------------
// Link timing
// ----------------------------------------
`define SCK_HALF_NS      200
`define SCK_HALF_CYC     `NS2CYC(`SCK_HALF_NS)
`define RST_PULSE_NS     2000
`define RST_CYC          `NS2CYC(`RST_PULSE_NS)
`define PWRUP_NS         20000000
`define PWRUP_CYC        `NS2CYC(`PWRUP_NS)
`define FLASH_WAIT_NS    4500000
`define FLASH_WAIT_CYC   `NS2CYC(`FLASH_WAIT_NS)
`define LONG_WAIT_NS     9000000
`define LONG_WAIT_CYC    `NS2CYC(`LONG_WAIT_NS)
`define TMR_W            20
`define DIV_W            4

// ----------------------------------------
// Instruction bytes
// ----------------------------------------
`define INSTR_BITS       32
`define OP_PROG_EN       8'hAC
`define OP_EN2           8'h53
`define OP_ERASE2        8'h80
`define OP_POLL          8'hF0
`define OP_LOAD_LO       8'h40
`define OP_LOAD_HI       8'h48

`endif

// >>> logic/prog_pkg.sv
`default_nettype none

package prog_pkg;

   // Wait after an instruction before the next one
   typedef enum logic [1:0] {
      WAIT_NONE  = 2'b00,
      WAIT_SHORT = 2'b01,
      WAIT_LONG  = 2'b10
   } wait_e;

   // Controller states
   typedef enum logic [2:0] {
      ST_OFF    = 3'b000,
      ST_RST_HI = 3'b001,
      ST_PWRUP  = 3'b010,
      ST_IDLE   = 3'b011,
      ST_SHIFT  = 3'b100,
      ST_WAIT   = 3'b101
   } state_e;

   // User command: four instruction bytes, first byte in bits 31:24
   typedef struct packed {
      wait_e       wait_kind;
      logic [31:0] instr;
   } cmd_s;

endpackage : prog_pkg

`default_nettype wire

// >>> logic/rsp_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module rsp_buffer (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   input  wire logic [7:0] in_data_i,
   output logic            out_valid_o,
   input  wire logic       out_ready_i,
   output logic [7:0]      out_data_o
);

   logic [7:0] mem_reg [2];
   logic       wr_ptr_reg;
   logic       rd_ptr_reg;
   logic [1:0] count_reg;
   wire        push;
   wire        pop;

   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   assign in_ready_o  = (count_reg != 2'h2);
   assign out_valid_o = (count_reg != 2'h0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_reg[rd_ptr_reg];

   // Storage and pointers
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
      if (rst_i) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg ^ push;
         rd_ptr_reg <= rd_ptr_reg ^ pop;
         count_reg  <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : rsp_buffer

`default_nettype wire

// >>> logic/serial_prog_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "prog_consts.svh"

module serial_prog_host #(
   parameter int unsigned PWRUP_CYC      = `PWRUP_CYC,
   parameter int unsigned FLASH_WAIT_CYC = `FLASH_WAIT_CYC,
   parameter int unsigned LONG_WAIT_CYC  = `LONG_WAIT_CYC
) (
   input  wire logic           REF_CLK_I,
   input  wire logic           RST_I,
   input  wire logic           SESSION_I,
   input  wire logic           CMD_VALID_I,
   input  wire prog_pkg::cmd_s CMD_I,
   output logic                CMD_READY_O,
   output logic                RSP_VALID_O,
   input  wire logic           RSP_READY_I,
   output logic [7:0]          RSP_DATA_O,
   output logic                ENABLED_O,
   output logic                ORDER_ERR_O,
   output logic                SCK_O,
   output logic                MOSI_O,
   input  wire logic           MISO_I,
   output logic                DEV_RST_N_O
);

   localparam logic [31:0] EN_INSTR = {`OP_PROG_EN, `OP_EN2, 16'h0000};
   localparam int          RST_CYC_I = `RST_CYC;

   prog_pkg::state_e  state_reg;
   prog_pkg::state_e  state_next;
   prog_pkg::wait_e   kind_reg;
   logic [`TMR_W-1:0] tmr_reg;
   logic [`TMR_W-1:0] tmr_next;
   logic [`DIV_W-1:0] div_reg;
   logic [4:0]        bit_reg;
   logic [31:0]       tx_reg;
   logic [31:0]       rx_reg;
   logic              sck_reg;
   logic              is_en_reg;
   logic              en_reg;
   logic              en_next;
   logic              dev_rst_n_reg;
   logic              dev_rst_n_next;
   logic              load_en;
   logic              load_cmd;
   logic              miso_meta_reg;
   logic              miso_sync_reg;
   logic [15:0]       lo_addr_reg;
   logic              lo_valid_reg;
   logic              order_err_reg;
   wire               tick;
   wire               shift_done;
   wire               echo_ok;
   wire               cmd_take;
   wire               rsp_push;
   wire               buf_ready;
   wire               tmr_zero;
   wire [`TMR_W-1:0]  wait_cyc;
   wire [31:0]        tx_load;
   wire               is_load_lo;
   wire               is_load_hi;

   // ----------------------------------------
   // Decode and selection
   // ----------------------------------------
   assign tick       = (state_reg == prog_pkg::ST_SHIFT) && (div_reg == `DIV_W'(`SCK_HALF_CYC - 1));
   assign shift_done = tick && sck_reg && (bit_reg == 5'h1F);
   assign echo_ok    = (rx_reg[15:8] == `OP_EN2);
   assign cmd_take   = CMD_VALID_I && CMD_READY_O;
   assign rsp_push   = shift_done && !is_en_reg;
   assign tmr_zero   = (tmr_reg == `TMR_W'(0));
   assign tx_load    = load_en ? EN_INSTR : CMD_I.instr;
   // Flash and fuse writes take the short wait, EEPROM and erase the long
   assign wait_cyc   = (kind_reg == prog_pkg::WAIT_SHORT) ? `TMR_W'(FLASH_WAIT_CYC)
                                                         : `TMR_W'(LONG_WAIT_CYC);
   // Load byte carries the word address bits in bytes two and three
   assign is_load_lo = (CMD_I.instr[31:24] == `OP_LOAD_LO);
   assign is_load_hi = (CMD_I.instr[31:24] == `OP_LOAD_HI);

   // Commands only once enabled, idle and with room for the answer
   assign CMD_READY_O = (state_reg == prog_pkg::ST_IDLE) && en_reg && SESSION_I && buf_ready;
   assign SCK_O       = sck_reg;
   assign MOSI_O      = tx_reg[31];
   assign DEV_RST_N_O = dev_rst_n_reg;
   assign ENABLED_O   = en_reg;
   assign ORDER_ERR_O = order_err_reg;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_next     = state_reg;
      tmr_next       = tmr_zero ? tmr_reg : tmr_reg - `TMR_W'(1);
      en_next        = en_reg;
      dev_rst_n_next = dev_rst_n_reg;
      load_en        = 1'b0;
      load_cmd       = 1'b0;
      case (state_reg)
         prog_pkg::ST_OFF: begin
            if (SESSION_I) begin
               // Clock already low: pulse reset high first
               state_next     = prog_pkg::ST_RST_HI;
               tmr_next       = `TMR_W'(RST_CYC_I);
               dev_rst_n_next = 1'b1;
            end
         end
         prog_pkg::ST_RST_HI: begin
            if (tmr_zero) begin
               state_next     = prog_pkg::ST_PWRUP;
               tmr_next       = `TMR_W'(PWRUP_CYC);
               dev_rst_n_next = 1'b0;
            end
         end
         prog_pkg::ST_PWRUP: begin
            if (tmr_zero) begin
               state_next = prog_pkg::ST_SHIFT;
               load_en    = 1'b1;
            end
         end
         prog_pkg::ST_IDLE: begin
            if (!SESSION_I) begin
               state_next     = prog_pkg::ST_OFF;
               dev_rst_n_next = 1'b1;
               en_next        = 1'b0;
            end else if (cmd_take) begin
               state_next = prog_pkg::ST_SHIFT;
               load_cmd   = 1'b1;
            end
         end
         prog_pkg::ST_SHIFT: begin
            if (shift_done) begin
               if (is_en_reg && echo_ok) begin
                  state_next = prog_pkg::ST_IDLE;
                  en_next    = 1'b1;
               end else if (is_en_reg) begin
                  // Out of sync: reset pulse, then a fresh enable
                  state_next     = prog_pkg::ST_RST_HI;
                  tmr_next       = `TMR_W'(RST_CYC_I);
                  dev_rst_n_next = 1'b1;
               end else if (kind_reg == prog_pkg::WAIT_NONE) begin
                  state_next = prog_pkg::ST_IDLE;
               end else begin
                  state_next = prog_pkg::ST_WAIT;
                  tmr_next   = wait_cyc;
               end
            end
         end
         prog_pkg::ST_WAIT: begin
            if (tmr_zero) begin
               state_next = prog_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = prog_pkg::ST_OFF;
         end
      endcase
   end

   // State, timer and reset pin
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         state_reg     <= prog_pkg::ST_OFF;
         tmr_reg       <= `TMR_W'(0);
         en_reg        <= 1'b0;
         dev_rst_n_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         tmr_reg       <= tmr_next;
         en_reg        <= en_next;
         dev_rst_n_reg <= dev_rst_n_next;
      end
   end

   // Data in synchroniser
   always_ff @(posedge REF_CLK_I) begin
      miso_meta_reg <= MISO_I;
      miso_sync_reg <= miso_meta_reg;
   end

   // ----------------------------------------
   // Shift engine
   // ----------------------------------------
   // Sample data out at the end of low phase, shift ours after falling edge
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         tx_reg    <= 32'h0000_0000;
         rx_reg    <= 32'h0000_0000;
         div_reg   <= `DIV_W'(0);
         bit_reg   <= 5'h00;
         sck_reg   <= 1'b0;
         is_en_reg <= 1'b0;
         kind_reg  <= prog_pkg::WAIT_NONE;
      end else if (load_en || load_cmd) begin
         tx_reg    <= tx_load;
         div_reg   <= `DIV_W'(0);
         bit_reg   <= 5'h00;
         sck_reg   <= 1'b0;
         is_en_reg <= load_en;
         kind_reg  <= load_en ? prog_pkg::WAIT_NONE : CMD_I.wait_kind;
      end else if (tick) begin
         div_reg <= `DIV_W'(0);
         sck_reg <= !sck_reg;
         if (!sck_reg) begin
            rx_reg <= {rx_reg[30:0], miso_sync_reg};
         end else begin
            tx_reg  <= {tx_reg[30:0], 1'b0};
            bit_reg <= bit_reg + 5'h01;
         end
      end else if (state_reg == prog_pkg::ST_SHIFT) begin
         div_reg <= div_reg + `DIV_W'(1);
      end
   end

   // Low-before-high load order tracking
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         lo_addr_reg   <= 16'h0000;
         lo_valid_reg  <= 1'b0;
         order_err_reg <= 1'b0;
      end else begin
         order_err_reg <= cmd_take && is_load_hi && !(lo_valid_reg && lo_addr_reg == CMD_I.instr[23:8]);
         if (cmd_take && (is_load_lo || is_load_hi)) begin
            lo_addr_reg  <= CMD_I.instr[23:8];
            lo_valid_reg <= is_load_lo;
         end
      end
   end

   // ----------------------------------------
   // Answer buffer
   // ----------------------------------------
   rsp_buffer u_rsp_buffer (
      .clk_i       (REF_CLK_I),
      .rst_i       (RST_I),
      .in_valid_i  (rsp_push),
      .in_ready_o  (buf_ready),
      .in_data_i   (rx_reg[7:0]),
      .out_valid_o (RSP_VALID_O),
      .out_ready_i (RSP_READY_I),
      .out_data_o  (RSP_DATA_O)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [7:0]        hi_cnt_reg;
   logic [`TMR_W-1:0] lo_cnt_reg;
   logic [`TMR_W-1:0] wait_cnt_reg;

   // Pin phase and wait length counters
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         hi_cnt_reg   <= 8'h00;
         lo_cnt_reg   <= `TMR_W'(0);
         wait_cnt_reg <= `TMR_W'(0);
      end else begin
         hi_cnt_reg   <= !dev_rst_n_reg ? 8'h00 : (hi_cnt_reg == 8'hFF ? hi_cnt_reg : hi_cnt_reg + 8'h01);
         lo_cnt_reg   <= dev_rst_n_reg ? `TMR_W'(0) : (&lo_cnt_reg ? lo_cnt_reg : lo_cnt_reg + `TMR_W'(1));
         wait_cnt_reg <= (state_reg == prog_pkg::ST_WAIT) ? wait_cnt_reg + `TMR_W'(1) : `TMR_W'(0);
      end
   end

   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_sck_high_phase;
      SCK_O [*5] ##1 !SCK_O;
   endsequence

   a_link_in_reset:
      assert property (SCK_O |-> !DEV_RST_N_O) else $error("Clock toggles while reset released");
   a_enable_first:
      assert property ((state_reg == prog_pkg::ST_SHIFT && !is_en_reg) |-> en_reg)
      else $error("Command shifted before enable");
   a_mosi_stable_high:
      assert property ((SCK_O && $past(SCK_O)) |-> $stable(MOSI_O)) else $error("Data moved while clock high");
   a_sck_phase_len:
      assert property ($rose(SCK_O) |-> s_sck_high_phase) else $error("Clock high phase wrong length");
   a_rst_pulse_len:
      assert property ($fell(DEV_RST_N_O) |-> $past(hi_cnt_reg) >= RST_CYC_I) else $error("Reset pulse too short");
   a_pwrup_wait_len:
      assert property (load_en |-> lo_cnt_reg >= PWRUP_CYC) else $error("Enable sent too early");
   a_echo_retry:
      assert property ((shift_done && is_en_reg && !echo_ok) |=> DEV_RST_N_O && !en_reg)
      else $error("No reset pulse after missing echo");
   a_short_wait_len:
      assert property (($fell(state_reg == prog_pkg::ST_WAIT) && kind_reg == prog_pkg::WAIT_SHORT)
                       |-> $past(wait_cnt_reg) >= FLASH_WAIT_CYC) else $error("Flash wait too short");
   a_long_wait_len:
      assert property (($fell(state_reg == prog_pkg::ST_WAIT) && kind_reg == prog_pkg::WAIT_LONG)
                       |-> $past(wait_cnt_reg) >= LONG_WAIT_CYC) else $error("EEPROM wait too short");
   a_session_end:
      assert property ((state_reg == prog_pkg::ST_IDLE && !SESSION_I) |=> DEV_RST_N_O && !ENABLED_O)
      else $error("Reset not released at session end");

endmodule : serial_prog_host

`default_nettype wire

// >>> verif/prog_device_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Programmed device, serial side
// ----------------------------------------
module prog_device_model #(
   parameter int         FL_NS = 30000,
   parameter int         EE_NS = 34000,
   parameter logic [7:0] OP_WP = 8'h4C, // Arbitrary page write opcode
   parameter logic [7:0] OP_WE = 8'hC0  // Arbitrary EEPROM write opcode
) (
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic rst_n_i,
   input  wire logic desync_i,
   output logic      miso_o
);
   logic [31:0] rx = '0;
   logic [7:0]  sh = '0;
   logic [7:0]  fl [16384];
   logic [7:0]  pb [128];
   logic [7:0]  ee [512];
   int          cnt = 0;
   int          bpg = -1;
   int          bee = -1;
   logic        en = 1'b0;
   realtime     bt = 0;

   // Whole arrays to FFh
   task automatic wipe();
      foreach (fl[i]) fl[i] = 8'hFF;
      foreach (ee[i]) ee[i] = 8'hFF;
      foreach (pb[i]) pb[i] = 8'hFF;
   endtask : wipe

   // Byte 4 answer
   function automatic logic [7:0] rd(logic [23:0] r);
      logic bz;
      bz = $realtime < bt;
      if (!en) return r[7:0];
      case (r[23:16])
         8'hF0: return {7'h00, bz};
         8'h20, 8'h28: return (bz && r[12:6] == bpg) ? 8'hFF : fl[{r[12:0], r[19]}];
         8'hA0: return (bz && r[8:0] == bee) ? 8'hFF : ee[r[8:0]];
         default: return r[7:0];
      endcase
   endfunction : rd

   // Carry out a whole instruction
   task automatic exec();
      if (rx[31:16] == 16'hAC53 && !desync_i) en = 1'b1;
      if (!en) return;
      if (rx[31:16] == 16'hAC80) begin
         wipe();
         bt = $realtime + EE_NS;
      end else if (rx[31:24] == 8'h40 || rx[31:24] == 8'h48) begin
         pb[{rx[13:8], rx[27]}] = rx[7:0];
      end else if (rx[31:24] == OP_WP) begin
         for (int i = 0; i < 128; i++) begin
            fl[{rx[20:14], i[6:0]}] = pb[i];
            pb[i] = 8'hFF;
         end
         bpg = rx[20:14];
         bee = -1;
         bt = $realtime + FL_NS;
      end else if (rx[31:24] == OP_WE) begin
         ee[rx[16:8]] = rx[7:0];
         bee = rx[16:8];
         bpg = -1;
         bt = $realtime + EE_NS;
      end
   endtask : exec

   initial wipe();

   // Reset high leaves programming mode, data out line inverted
   always @(posedge rst_n_i) begin
      en = 1'b0;
      cnt = 0;
      miso_o = ~miso_o;
   end

   // Sample on rising clock
   always @(posedge sck_i) if (!rst_n_i) begin
      rx = {rx[30:0], mosi_i};
      cnt++;
      if (cnt == 32) begin
         exec();
         cnt = 0;
      end
   end

   // Shift on falling clock, previous byte echoed
   always @(negedge sck_i) if (!rst_n_i) begin
      sh = (cnt == 16) ? (desync_i ? ~rx[7:0] : rx[7:0]) : (cnt == 24) ? rd(rx[23:0]) :
           (cnt == 8) ? rx[7:0] : {sh[6:0], ~sh[0]};
      miso_o = sh[7];
   end
endmodule : prog_device_model

`default_nettype wire

// >>> verif/test_serial_prog_host.sv
`timescale 1ns/1ps
`default_nettype none

module test_serial_prog_host;
   localparam int         PW = 20, FW = 800, LW = 900, CPU_NS = 63;
   localparam logic [7:0] WP = 8'h4C, WE = 8'hC0;
   logic           clk = 1'b0, rst = 1'b1, session = 1'b0, cmd_valid = 1'b0;
   logic           rsp_ready = 1'b0, desync = 1'b1, stall = 1'b0;
   logic           sck_d = 1'b0, mosi_d = 1'b0, rst_d = 1'b0, first = 1'b0;
   prog_pkg::cmd_s cmd = '0;
   wire logic      cmd_ready, rsp_valid, enabled, order_err, sck, mosi, miso, dev_rst_n;
   wire logic [7:0] rsp_data;
   int             err_total = 0, checked = 0, seed = 32'hbebe;
   int             oe_cnt = 0, pulses = 0, ph = 0, rh = 0, since = 0, pg, a, d;
   logic [7:0]     expq [$];
   logic [7:0]     rfl [int] = '{default: 8'hFF};
   logic [7:0]     ree [int] = '{default: 8'hFF};

   serial_prog_host #(.PWRUP_CYC(PW), .FLASH_WAIT_CYC(FW), .LONG_WAIT_CYC(LW)) dut_u (
      .REF_CLK_I(clk), .RST_I(rst), .SESSION_I(session), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
      .CMD_READY_O(cmd_ready), .RSP_VALID_O(rsp_valid), .RSP_READY_I(rsp_ready), .RSP_DATA_O(rsp_data),
      .ENABLED_O(enabled), .ORDER_ERR_O(order_err), .SCK_O(sck), .MOSI_O(mosi), .MISO_I(miso),
      .DEV_RST_N_O(dev_rst_n));
   prog_device_model #(.OP_WP(WP), .OP_WE(WE)) dev_u (
      .sck_i(sck), .mosi_i(mosi), .rst_n_i(dev_rst_n), .desync_i(desync), .miso_o(miso));

   initial forever #20 clk = ~clk;

   task automatic check(input logic ok, input string m);
      checked++;
      if (!ok) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : check

   task automatic results();
      $display("checked %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results

   function automatic logic cond(int k);
      return k == 0 ? enabled === 1'b1 : k == 1 ? expq.size() == 0 : dev_rst_n === 1'b1;
   endfunction : cond

   task automatic await(input int k, input int lim);
      int n;
      for (n = 0; n < lim && !cond(k); n++) @(posedge clk);
      if (n == lim) begin
         check(1'b0, "wait timed out");
         results();
      end
   endtask : await

   function automatic logic [31:0] fw(logic [7:0] op, int w, logic [7:0] dt);
      return {op, 3'b000, w[12:0], dt};
   endfunction : fw

   // Offer one command, queue its answer (negative: echo of byte 3)
   task automatic send(input prog_pkg::wait_e wk, input logic [31:0] ins, input int ex);
      int n;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{wait_kind: wk, instr: ins};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 20000);
      cmd_valid <= 1'b0;
      expq.push_back(ex < 0 ? ins[15:8] : ex[7:0]);
      if (n >= 20000) await(3, 0);
   endtask : send

   task automatic rdf(input int w, input logic hi);
      send(prog_pkg::WAIT_NONE, fw({4'h2, hi, 3'b000}, w, 8'h00), rfl[w * 2 + hi]);
   endtask : rdf

   // Consumer with random stalls
   always @(posedge clk) rsp_ready <= !stall && ($random(seed) & 1) != 0;

   // Answers against the reference queue
   always @(posedge clk) if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (expq.size() == 0) check(1'b0, "answer not expected");
      else check(rsp_data === expq.pop_front(), "answer byte");
   end

   // Retry counting, echo broken on the first attempt
   always @(posedge dev_rst_n) begin
      pulses++;
      if (pulses == 2) desync <= 1'b0;
   end

   // Link pin monitor
   always @(posedge clk) if (!rst) begin
      if (sck !== sck_d) begin
         check(ph * 40 > 3 * CPU_NS, "clock phase too short");
         ph = 0;
      end
      if (sck === 1'b1 && sck_d === 1'b1 && mosi !== mosi_d) check(1'b0, "data moved in high phase");
      if (dev_rst_n === 1'b1 && sck !== 1'b0) check(1'b0, "clock outside programming");
      if (rst_d === 1'b1 && dev_rst_n === 1'b0) begin
         check(rh * 40 >= 2 * CPU_NS, "reset pulse too short");
         since = 0;
         first = 1'b1;
      end
      if (first && sck === 1'b1) begin
         check(since >= PW, "enable sent too early");
         first = 1'b0;
      end
      if (order_err === 1'b1) oe_cnt++;
      rh = dev_rst_n === 1'b1 ? rh + 1 : 0;
      ph++;
      since++;
      sck_d = sck;
      mosi_d = mosi;
      rst_d = dev_rst_n;
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check(sck === 1'b0 && dev_rst_n === 1'b0 && enabled === 1'b0 && cmd_ready === 1'b0, "reset state");
      session <= 1'b1;
      repeat (100) @(posedge clk);
      check(cmd_ready === 1'b0, "ready before enable");
      await(0, 3000);
      check(pulses == 2, "no retry after missing echo");
      $display("test enable done");
      pg = $random(seed) & 127;
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         rfl[(pg * 64 + i) * 2] = d[7:0];
         rfl[(pg * 64 + i) * 2 + 1] = d[15:8];
         send(prog_pkg::WAIT_NONE, fw(8'h40, pg * 64 + i, d[7:0]), -1);
         send(prog_pkg::WAIT_NONE, fw(8'h48, pg * 64 + i, d[15:8]), -1);
      end
      rfl[(pg * 64 + 4) * 2 + 1] = 8'h5A;
      send(prog_pkg::WAIT_NONE, fw(8'h48, pg * 64 + 4, 8'h5A), -1);
      send(prog_pkg::WAIT_SHORT, fw(WP, pg * 64, 8'h00), -1);
      for (int i = 0; i < 10; i++) rdf(pg * 64 + i / 2, i[0]);
      check(oe_cnt == 1, "high byte order flag");
      $display("test page load done");
      pg = (pg + 1) & 127;
      d = $random(seed);
      send(prog_pkg::WAIT_NONE, fw(8'h40, pg * 64, d[7:0]), -1);
      send(prog_pkg::WAIT_NONE, fw(WP, pg * 64, 8'h00), -1);
      send(prog_pkg::WAIT_NONE, fw(8'h20, pg * 64, 8'h00), 8'hFF);
      send(prog_pkg::WAIT_NONE, 32'hF0000000, 1);
      rfl[pg * 128] = d[7:0];
      rdf(pg * 64, 1'b0);
      $display("test page polling done");
      a = $random(seed) & 511;
      d = $random(seed);
      ree[a] = d[7:0];
      send(prog_pkg::WAIT_LONG, fw(WE, a, d[7:0]), -1);
      send(prog_pkg::WAIT_NONE, fw(8'hA0, a, 8'h00), ree[a]);
      send(prog_pkg::WAIT_NONE, fw(WE, a, d[15:8]), -1);
      send(prog_pkg::WAIT_NONE, fw(8'hA0, a, 8'h00), 8'hFF);
      send(prog_pkg::WAIT_NONE, fw(8'hA0, a, 8'h00), 8'hFF);
      send(prog_pkg::WAIT_NONE, fw(8'hA0, a, 8'h00), d[15:8]);
      $display("test eeprom done");
      // Pending answer plus one more fill both entries; next command must wait
      stall <= 1'b1;
      rdf(pg * 64, 1'b0);
      repeat (400) @(posedge clk);
      check(cmd_ready === 1'b0 && rsp_valid === 1'b1, "full buffer not holding");
      stall <= 1'b0;
      rdf(pg * 64, 1'b1);
      await(1, 2000);
      $display("test buffer done");
      send(prog_pkg::WAIT_LONG, 32'hAC800000, -1);
      rfl.delete();
      ree.delete();
      rdf(pg * 64, 1'b0);
      send(prog_pkg::WAIT_NONE, fw(8'hA0, a, 8'h00), 8'hFF);
      await(1, 2000);
      $display("test erase done");
      session <= 1'b0;
      await(2, 2000);
      repeat (2) @(posedge clk);
      check(enabled === 1'b0 && dev_rst_n === 1'b1, "session end");
      $display("test session end done");
      results();
   end
endmodule : test_serial_prog_host

`default_nettype wire
